// ### core/rsm_top.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Pin, supply, watchdog resets drive shared line
// - Fetch vector pair at top of memory
// - Active phase, delay, then vector fetch
// - Delay 256 cycles, crystal uses 4096
// - Vector fetch lasts exactly two cycles
// - PLL enabled adds start-up wait to clock
// - Reset pin is input and open-drain output
// - External low pulse caught without clock
// - Illegal opcode or prefix starts reset
// - Watchdog underflow drives pin minimum pulse
// - Static reset while supply below threshold
// - Threshold level and detector enable options
// - Bit 1 shows warning comparator live
// - Warning detector off unless detector enabled
// - Warning interrupt needs enable and clear mask
// - Pending warning cleared on service entry
// - Warning wakes from Wait only
// - Halt freezes warning and lock bits, no warning wake
// - Watchdog flag: hardware set, write-zero clear
// - Undervoltage flag set on reset, read clears
// - Two flags encode the reset cause
// - Lock flag follows PLL, hardware only
module rsm_top #(
    parameter int unsigned PLL_STARTUP_CYC = rsm_pkg::PLL_STARTUP_CYC_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe,
    input wire logic lvdCompLow,
    input wire logic avdCompLow,
    input wire logic pllLockIn,
    input wire logic wdgUnderflow,
    input wire logic illegalOpcode,
    input wire logic illegalPrefix,
    input wire logic optUvdEnable,
    input wire logic [1:0] optUvdLevel,
    input wire logic optCrystalOsc,
    input wire logic optPllEnable,
    input wire logic cpuIntMask,
    input wire logic haltMode,
    input wire logic waitMode,
    input wire logic avdIsrEntry,
    input wire rsm_pkg::rsm_bus_req_t busReq,
    output logic [7:0] busRdata,
    output logic coreResetN,
    output logic vectorFetch,
    output logic [15:0] vectorAddr,
    output logic pllClkOutEn,
    output logic uvdEnable,
    output logic [1:0] uvdLevel,
    output logic avdEnable,
    output logic avdIrq,
    output logic waitWake
);

    // ---------------------------------------------
    // Reset release
    // ---------------------------------------------
    logic [1:0] rstPipe_q;
    logic rstN;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe_q <= 2'b00;
        end else if (clkEn) begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstN = rstPipe_q[1];

    // ---------------------------------------------
    // External pin capture
    // ---------------------------------------------
    rsm_pkg::rsm_state_t state_q;
    rsm_pkg::rsm_state_t state_d;
    logic extHit_q;
    logic extArm_q;
    logic extClr;

    // Clearing while armed off avoids re-triggering on our own drive,
    // which the filter still shows for a few cycles after release.
    assign extClr = !rstN || (state_q == rsm_pkg::RSM_FETCH) ||
                    ((state_q == rsm_pkg::RSM_RUN) && !extArm_q);

    always_ff @(posedge clk or negedge resetPinIn) begin
        if (!resetPinIn) begin
            extHit_q <= 1'b1;
        end else if (clkEn && extClr) begin
            extHit_q <= 1'b0;
        end
    end

    // ---------------------------------------------
    // Input synchronisers and filters
    // ---------------------------------------------
    logic [rsm_pkg::NSYNC-1:0] asyncIn;
    logic [rsm_pkg::NSYNC-1:0] s1_q;
    logic [rsm_pkg::NSYNC-1:0] s2_q;
    logic [rsm_pkg::NSYNC-1:0] s3_q;
    logic [rsm_pkg::NSYNC-1:0] filt_q;

    assign asyncIn[rsm_pkg::SY_PIN] = ~resetPinIn;
    assign asyncIn[rsm_pkg::SY_LVD] = lvdCompLow;
    assign asyncIn[rsm_pkg::SY_AVD] = avdCompLow;
    assign asyncIn[rsm_pkg::SY_LOCK] = pllLockIn;
    assign asyncIn[rsm_pkg::SY_EXT] = extHit_q;

    genvar gi;
    generate
        for (gi = 0; gi < rsm_pkg::NSYNC; gi = gi + 1) begin : gSync
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    filt_q[gi] <= 1'b0;
                end else if (clkEn) begin
                    s1_q[gi] <= asyncIn[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------
    // Option sampling
    // ---------------------------------------------
    logic uvdEn_q;
    logic [1:0] uvdLevel_q;
    logic crystal_q;
    logic pllEn_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            uvdEn_q <= 1'b0;
            uvdLevel_q <= 2'b00;
            crystal_q <= 1'b0;
            pllEn_q <= 1'b0;
        end else if (clkEn) begin
            uvdEn_q <= optUvdEnable;
            uvdLevel_q <= optUvdLevel;
            crystal_q <= optCrystalOsc;
            pllEn_q <= optPllEnable;
        end
    end
    assign uvdEnable = uvdEn_q;
    assign uvdLevel = uvdLevel_q;
    assign avdEnable = uvdEn_q;

    // ---------------------------------------------
    // Reset sources
    // ---------------------------------------------
    logic lvdReq;
    logic intTrig;
    logic extReq;
    logic pinLow;
    logic [7:0] pulse_q;
    logic intPulse;

    assign lvdReq = filt_q[rsm_pkg::SY_LVD] & uvdEn_q;
    assign intTrig = wdgUnderflow | illegalOpcode | illegalPrefix;
    assign extReq = filt_q[rsm_pkg::SY_EXT] & extArm_q;
    assign pinLow = filt_q[rsm_pkg::SY_PIN];
    assign intPulse = (pulse_q != 8'h00);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pulse_q <= 8'h00;
        end else if (clkEn) begin
            if (intTrig) begin
                pulse_q <= rsm_pkg::MIN_RST_OUT_CYC;
            end else if (intPulse) begin
                pulse_q <= pulse_q - rsm_pkg::PULSE_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            extArm_q <= 1'b0;
        end else if (clkEn) begin
            if (state_q != rsm_pkg::RSM_RUN) begin
                extArm_q <= 1'b0;
            end else if (!filt_q[rsm_pkg::SY_EXT]) begin
                extArm_q <= 1'b1;
            end
        end
    end

    // ---------------------------------------------
    // Sequencer
    // ---------------------------------------------
    logic [31:0] cnt_q;
    logic fetchLast_q;
    logic holdActive;
    logic [31:0] dlyLast;
    logic [31:0] pllLast;

    assign holdActive = lvdReq | intPulse | intTrig | pinLow;
    assign dlyLast = crystal_q ? rsm_pkg::DLY_LONG_LAST :
                                 rsm_pkg::DLY_SHORT_LAST;
    assign pllLast = (PLL_STARTUP_CYC > 0) ?
                     (PLL_STARTUP_CYC - rsm_pkg::CNT_ONE) : 32'h00000000;

    always_comb begin
        state_d = state_q;
        case (state_q)
            rsm_pkg::RSM_RUN: begin
                if (extReq || lvdReq || intTrig || intPulse) begin
                    state_d = rsm_pkg::RSM_ACTIVE;
                end
            end
            rsm_pkg::RSM_ACTIVE: begin
                if (!holdActive) begin
                    state_d = rsm_pkg::RSM_DELAY;
                end
            end
            rsm_pkg::RSM_DELAY: begin
                if (lvdReq || intTrig || intPulse) begin
                    state_d = rsm_pkg::RSM_ACTIVE;
                end else if (cnt_q == 32'h00000000) begin
                    state_d = pllEn_q ? rsm_pkg::RSM_PLLW :
                                        rsm_pkg::RSM_FETCH;
                end
            end
            rsm_pkg::RSM_PLLW: begin
                if (lvdReq || intTrig || intPulse) begin
                    state_d = rsm_pkg::RSM_ACTIVE;
                end else if (cnt_q == 32'h00000000) begin
                    state_d = rsm_pkg::RSM_FETCH;
                end
            end
            rsm_pkg::RSM_FETCH: begin
                if (fetchLast_q) begin
                    state_d = rsm_pkg::RSM_RUN;
                end
            end
            default: begin
                state_d = rsm_pkg::RSM_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= rsm_pkg::RSM_ACTIVE;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt_q <= 32'h00000000;
        end else if (clkEn) begin
            if (state_d == rsm_pkg::RSM_DELAY &&
                state_q != rsm_pkg::RSM_DELAY) begin
                cnt_q <= dlyLast;
            end else if (state_d == rsm_pkg::RSM_PLLW &&
                         state_q != rsm_pkg::RSM_PLLW) begin
                cnt_q <= pllLast;
            end else if (cnt_q != 32'h00000000) begin
                cnt_q <= cnt_q - rsm_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            fetchLast_q <= 1'b0;
            vectorAddr <= rsm_pkg::VEC_ADDR_HI;
        end else if (clkEn) begin
            fetchLast_q <= (state_d == rsm_pkg::RSM_FETCH) &&
                           (state_q == rsm_pkg::RSM_FETCH);
            if (state_d == rsm_pkg::RSM_FETCH &&
                state_q == rsm_pkg::RSM_FETCH) begin
                vectorAddr <= rsm_pkg::VEC_ADDR_LO;
            end else begin
                vectorAddr <= rsm_pkg::VEC_ADDR_HI;
            end
        end
    end

    assign vectorFetch = (state_q == rsm_pkg::RSM_FETCH);
    assign coreResetN = (state_q == rsm_pkg::RSM_RUN);
    assign pllClkOutEn = (state_q == rsm_pkg::RSM_FETCH) ||
                         (state_q == rsm_pkg::RSM_RUN);

    // ---------------------------------------------
    // Reset pin drive
    // ---------------------------------------------
    // open drain, low only
    assign resetPinOut = 1'b0;
    // line held low through the delay
    assign resetPinOe = (state_q == rsm_pkg::RSM_DELAY) ||
                        ((state_q == rsm_pkg::RSM_ACTIVE) &&
                         (lvdReq || intPulse || intTrig));

    // ---------------------------------------------
    // Status register
    // ---------------------------------------------
    logic wdgFlag_q;
    logic uvFlag_q;
    logic supply_warning_flag_q;
    logic lock_q;
    logic supply_warning_irq_enable_q;
    logic avdPend_q;
    logic selStatus;
    logic [7:0] statusWord;

    assign selStatus = (busReq.addr == rsm_pkg::ADDR_STATUS);

    always_comb begin
        statusWord = rsm_pkg::STATUS_RESET;
        statusWord[rsm_pkg::BIT_IE] = supply_warning_irq_enable_q;
        statusWord[rsm_pkg::BIT_SUPPLY_WARNING_FLAG] = supply_warning_flag_q;
        statusWord[rsm_pkg::BIT_UVF] = uvFlag_q;
        statusWord[rsm_pkg::BIT_LOCK] = lock_q;
        statusWord[rsm_pkg::BIT_WDGF] = wdgFlag_q;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            supply_warning_flag_q <= 1'b0;
            lock_q <= 1'b0;
        end else if (clkEn && !haltMode) begin
            supply_warning_flag_q <= filt_q[rsm_pkg::SY_AVD] & uvdEn_q;
            lock_q <= filt_q[rsm_pkg::SY_LOCK];
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wdgFlag_q <= 1'b0;
        end else if (clkEn) begin
            if (wdgUnderflow) begin
                wdgFlag_q <= 1'b1;
            end else if (lvdReq) begin
                wdgFlag_q <= 1'b0;
            end else if (busReq.wr && selStatus &&
                         !busReq.wdata[rsm_pkg::BIT_WDGF]) begin
                wdgFlag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            uvFlag_q <= 1'b0;
        end else if (clkEn) begin
            if (lvdReq) begin
                uvFlag_q <= 1'b1;
            end else if (busReq.rd && selStatus) begin
                uvFlag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            supply_warning_irq_enable_q <= 1'b0;
        end else if (clkEn && busReq.wr && selStatus) begin
            supply_warning_irq_enable_q <= busReq.wdata[rsm_pkg::BIT_IE];
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            busRdata <= 8'h00;
        end else if (clkEn) begin
            if (busReq.rd && selStatus) begin
                busRdata <= statusWord;
            end else begin
                busRdata <= 8'h00;
            end
        end
    end

    // ---------------------------------------------
    // Supply warning interrupt
    // ---------------------------------------------
    // service entry clears, new rise wins
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            avdPend_q <= 1'b0;
        end else if (clkEn) begin
            if (!haltMode && !supply_warning_flag_q &&
                filt_q[rsm_pkg::SY_AVD] && uvdEn_q) begin
                avdPend_q <= 1'b1;
            end else if (avdIsrEntry) begin
                avdPend_q <= 1'b0;
            end
        end
    end

    assign avdIrq = avdPend_q & supply_warning_irq_enable_q & ~cpuIntMask & ~haltMode &
                    coreResetN;
    assign waitWake = avdIrq & waitMode;

endmodule

// ### core/rsm_pkg.sv
package rsm_pkg;

    // ---------------------------------------------
    // Clock and timing
    // ---------------------------------------------
    localparam int CLK_MHZ = 100;
    // Shortest reset output pulse; value is a plain default
    localparam int MIN_RST_OUT_NS = 1000;
    localparam int MIN_RST_OUT_CYC_I = (MIN_RST_OUT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] MIN_RST_OUT_CYC = 8'(MIN_RST_OUT_CYC_I);
    // PLL start-up interval; value is a plain default
    localparam int PLL_STARTUP_US = 1000;
    localparam int unsigned PLL_STARTUP_CYC_DEF = PLL_STARTUP_US * CLK_MHZ;
    localparam logic [31:0] CNT_ONE = 32'h00000001;
    localparam logic [7:0] PULSE_ONE = 8'h01;

    // Stabilisation delay, loaded as count minus one
    localparam logic [31:0] DLY_SHORT_LAST = 32'h000000ff;
    localparam logic [31:0] DLY_LONG_LAST = 32'h00000fff;

    // Reset vector pair
    localparam logic [15:0] VEC_ADDR_HI = 16'hfffe;
    localparam logic [15:0] VEC_ADDR_LO = 16'hffff;

    // ---------------------------------------------
    // Register map
    // ---------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int BIT_IE = 0;
    localparam int BIT_SUPPLY_WARNING_FLAG = 1;
    localparam int BIT_UVF = 2;
    localparam int BIT_LOCK = 3;
    localparam int BIT_WDGF = 4;

    // ---------------------------------------------
    // Asynchronous input slots
    // ---------------------------------------------
    localparam int NSYNC = 5;
    localparam int SY_PIN = 0;
    localparam int SY_LVD = 1;
    localparam int SY_AVD = 2;
    localparam int SY_LOCK = 3;
    localparam int SY_EXT = 4;

    typedef enum logic [2:0] {
        RSM_ACTIVE = 3'b000,
        RSM_DELAY = 3'b001,
        RSM_PLLW = 3'b011,
        RSM_FETCH = 3'b010,
        RSM_RUN = 3'b110
    } rsm_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsm_bus_req_t;

endpackage

// ### tb/rsm_properties.sv
`timescale 1ns/1ps
module rsm_properties #(
    parameter int unsigned PLL_STARTUP_CYC = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic resetPinOe,
    input wire logic lvdCompLow,
    input wire logic wdgUnderflow,
    input wire logic illegalOpcode,
    input wire logic illegalPrefix,
    input wire logic optCrystalOsc,
    input wire logic optPllEnable,
    input wire logic cpuIntMask,
    input wire logic haltMode,
    input wire logic waitMode,
    input wire logic coreResetN,
    input wire logic vectorFetch,
    input wire logic [15:0] vectorAddr,
    input wire logic pllClkOutEn,
    input wire logic uvdEnable,
    input wire logic avdEnable,
    input wire logic avdIrq,
    input wire logic waitWake
);
    // ---------------------------------------------
    // Run counters
    // ---------------------------------------------
    // Wide enough for the full start-up wait of a real part
    logic [31:0] oeRunQ;
    logic [31:0] offRunQ;
    logic [31:0] dlyLen;
    logic [31:0] pllLen;
    assign dlyLen = optCrystalOsc ? 32'h00001000 : 32'h00000100;
    assign pllLen = optPllEnable ? 32'(PLL_STARTUP_CYC) : 32'h00000000;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oeRunQ <= 32'h00000000;
            offRunQ <= 32'h00000000;
        end else begin
            oeRunQ <= resetPinOe ? oeRunQ + 32'h00000001 : 32'h00000000;
            offRunQ <= pllClkOutEn ? 32'h00000000 : offRunQ + 32'h00000001;
        end
    end

    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_fetch_len;
        $rose(vectorFetch) |-> vectorFetch ##1 vectorFetch ##1 !vectorFetch;
    endproperty
    a_fetch_len: assert property (p_fetch_len)
        else $error("vector fetch not two cycles");
    property p_fetch_addr;
        $rose(vectorFetch) |-> vectorAddr == 16'hfffe ##1
            vectorAddr == 16'hffff;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("vector fetch address wrong");
    property p_fetch_run;
        $fell(vectorFetch) |-> coreResetN;
    endproperty
    a_fetch_run: assert property (p_fetch_run)
        else $error("core not released after fetch");
    property p_delay;
        $rose(vectorFetch) |-> offRunQ >= dlyLen + pllLen;
    endproperty
    a_delay: assert property (p_delay)
        else $error("clock output released too early");
    property p_oe_delay;
        $rose(vectorFetch) && !optPllEnable |-> oeRunQ >= dlyLen;
    endproperty
    a_oe_delay: assert property (p_oe_delay)
        else $error("reset line not low through delay");
    property p_wdg;
        wdgUnderflow && coreResetN |=> resetPinOe [*8];
    endproperty
    a_wdg: assert property (p_wdg)
        else $error("watchdog reset pulse missing");
    property p_lvd;
        (lvdCompLow && uvdEnable) [*8] |-> resetPinOe && !coreResetN;
    endproperty
    a_lvd: assert property (p_lvd)
        else $error("no static reset on low supply");
    property p_illegal;
        (illegalOpcode || illegalPrefix) && coreResetN |=> !coreResetN;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("illegal code did not reset");
    property p_irq;
        avdIrq |-> coreResetN && !cpuIntMask && !haltMode;
    endproperty
    a_irq: assert property (p_irq)
        else $error("warning request while masked");
    property p_wake;
        waitWake |-> waitMode && avdIrq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without warning request");
    property p_avd_off;
        !uvdEnable |-> !avdEnable && !avdIrq;
    endproperty
    a_avd_off: assert property (p_avd_off)
        else $error("warning detector on while disabled");
    c_fetch: cover property ($rose(vectorFetch));
    c_wdg: cover property (wdgUnderflow && coreResetN);
    c_irq: cover property (avdIrq);
    c_wake: cover property (waitWake);
endmodule

bind rsm_top rsm_properties #(.PLL_STARTUP_CYC(PLL_STARTUP_CYC)) u_props (
    .clk, .resetn, .resetPinOe, .lvdCompLow, .wdgUnderflow, .illegalOpcode,
    .illegalPrefix, .optCrystalOsc, .optPllEnable, .cpuIntMask, .haltMode,
    .waitMode, .coreResetN, .vectorFetch, .vectorAddr, .pllClkOutEn,
    .uvdEnable, .avdEnable, .avdIrq, .waitWake
);

// ### tb/rsm_reset_line.sv
`timescale 1ns/1ps
module rsm_reset_line (
    input wire logic pinOe,
    input wire logic pinOut,
    input wire logic extPullLow,
    output logic wireLevel
);
    // open-drain wire
    // The weak pull-up only wins while nobody sinks current
    assign wireLevel = ((pinOe && !pinOut) || extPullLow) ? 1'b0 : 1'b1;
endmodule

// ### tb/rsm_top_tb.sv
`timescale 1ns/1ps
module rsm_top_tb;
    // ---------------------------------------------
    // Stimulus and model state
    // ---------------------------------------------
    logic clk, resetn, clkEn, resetPinIn, resetPinOut, resetPinOe, extLow;
    logic lvdCompLow, avdCompLow, pllLockIn, wdgUnderflow, illegalOpcode;
    logic illegalPrefix, optUvdEnable, optCrystalOsc, optPllEnable;
    logic cpuIntMask, haltMode, waitMode, avdIsrEntry, coreResetN;
    logic vectorFetch, pllClkOutEn, uvdEnable, avdEnable, avdIrq, waitWake;
    logic [1:0] optUvdLevel, uvdLevel;
    logic [7:0] busRdata, rnd;
    logic [15:0] vectorAddr;
    rsm_pkg::rsm_bus_req_t busReq;
    int errCount, nChecks, ie, wdgF, uvdF;
    int causes[$];

    rsm_top #(.PLL_STARTUP_CYC(20)) uut (
        .clk, .resetn, .clkEn, .resetPinIn, .resetPinOut, .resetPinOe,
        .lvdCompLow, .avdCompLow, .pllLockIn, .wdgUnderflow, .illegalOpcode,
        .illegalPrefix, .optUvdEnable, .optUvdLevel, .optCrystalOsc,
        .optPllEnable, .cpuIntMask, .haltMode, .waitMode, .avdIsrEntry,
        .busReq, .busRdata, .coreResetN, .vectorFetch, .vectorAddr,
        .pllClkOutEn, .uvdEnable, .uvdLevel, .avdEnable, .avdIrq, .waitWake
    );
    rsm_reset_line u_line (.pinOe(resetPinOe), .pinOut(resetPinOut),
        .extPullLow(extLow), .wireLevel(resetPinIn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic miss(input string what);
        errCount++;
        $display("MISMATCH t=%0t %s", $time, what);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) miss($sformatf("reg got %h exp %h", got, exp));
    endtask
    task automatic chkb(input logic got, input logic exp);
        nChecks++;
        if (got !== exp) miss($sformatf("level got %b exp %b", got, exp));
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) miss($sformatf("value got %h exp %h", got, exp));
    endtask
    task automatic chkn(input int got, input int lo, input int hi);
        nChecks++;
        if (got < lo || got > hi) miss($sformatf("count %0d", got));
    endtask

    function automatic logic [7:0] stat(input logic supply_early_warning_detector);
        return {3'h0, wdgF[0], pllLockIn, uvdF[0], supply_early_warning_detector, ie[0]};
    endfunction

    // Bus cycles start and end on a rising edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        if (a == 4'h0) begin
            ie = d[0];
            wdgF = d[4] ? wdgF : 0;
        end
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic supply_early_warning_detector);
        logic [7:0] exp;
        exp = (a == 4'h0) ? stat(supply_early_warning_detector) : 8'h00;
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        if (a == 4'h0) begin
            uvdF = 0;
        end
        #1 chk8(busRdata, exp);
        @(posedge clk);
    endtask

    // Waits out a reset sequence, then applies its cause to the model
    task automatic runWait(input int lo, input int hi, input int minOe);
        int n;
        int oeN;
        int c;
        n = 0;
        oeN = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            oeN += int'(resetPinOe === 1'b1);
        end while (vectorFetch !== 1'b1 && n < 6000);
        chkn(n, lo, hi);
        chkn(oeN, minOe, 6000);
        chk16(vectorAddr, 16'hfffe);
        @(posedge clk);
        #1 chk16(vectorAddr, 16'hffff);
        chkb(vectorFetch, 1'b1);
        @(posedge clk);
        #1 chkb(vectorFetch, 1'b0);
        chkb(coreResetN, 1'b1);
        @(posedge clk);
        c = causes.pop_front();
        wdgF = (c == 1) ? 1 : (c == 2) ? 0 : wdgF;
        uvdF = (c == 2) ? 1 : uvdF;
        repeat (8) @(posedge clk);
    endtask

    task automatic finishTest;
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miss("watchdog expired");
        finishTest();
    end

    initial begin
        void'($urandom(11));
        {resetn, extLow, lvdCompLow, avdCompLow, wdgUnderflow} = '0;
        {illegalOpcode, illegalPrefix, optCrystalOsc, optPllEnable} = '0;
        {cpuIntMask, haltMode, waitMode, avdIsrEntry} = '0;
        {clkEn, optUvdEnable, pllLockIn} = 3'h7;
        optUvdLevel = 2'h0;
        busReq = '0;
        {ie, wdgF, uvdF, errCount, nChecks} = '0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        causes.push_back(0);
        runWait(258, 275, 256);
        rd(4'h0, 1'b0);
        rnd = 8'($urandom()) & 8'h1f;
        wr(4'h0, rnd);
        rd(4'h0, 1'b0);
        wr(4'h5, 8'h01);
        rd(4'h5, 1'b0);
        wr(4'h0, 8'h00);
        $display("test power-up and registers done");
        wdgUnderflow <= 1'b1;
        @(posedge clk);
        wdgUnderflow <= 1'b0;
        causes.push_back(1);
        #1 chkb(resetPinIn, 1'b0);
        runWait(350, 380, rsm_pkg::MIN_RST_OUT_CYC_I);
        wr(4'h0, 8'h10);
        rd(4'h0, 1'b0);
        wr(4'h0, 8'h00);
        $display("test watchdog done");
        for (int i = 0; i < 2; i++) begin
            optPllEnable <= i[0];
            repeat (8) @(posedge clk);
            illegalOpcode <= (i == 0);
            illegalPrefix <= (i == 1);
            @(posedge clk);
            illegalOpcode <= 1'b0;
            illegalPrefix <= 1'b0;
            causes.push_back(0);
            #1 chkb(coreResetN, 1'b0);
            runWait(350 + 20 * i, 380 + 20 * i, 100);
        end
        optPllEnable <= 1'b0;
        rd(4'h0, 1'b0);
        $display("test illegal code done");
        lvdCompLow <= 1'b1;
        repeat (300) @(posedge clk);
        #1 chkb(coreResetN, 1'b0);
        chkb(resetPinIn, 1'b0);
        @(posedge clk);
        lvdCompLow <= 1'b0;
        causes.push_back(2);
        runWait(256, 275, 256);
        optCrystalOsc <= 1'b1;
        extLow <= 1'b1;
        repeat (10 + $urandom_range(20)) @(posedge clk);
        #1 chkb(coreResetN, 1'b0);
        @(posedge clk);
        extLow <= 1'b0;
        causes.push_back(0);
        runWait(4096, 4115, 256);
        optCrystalOsc <= 1'b0;
        rd(4'h0, 1'b0);
        rd(4'h0, 1'b0);
        $display("test supply and pin resets done");
        wr(4'h0, 8'h01);
        cpuIntMask <= 1'b1;
        avdCompLow <= 1'b1;
        repeat (8) @(posedge clk);
        rd(4'h0, 1'b1);
        #1 chkb(avdIrq, 1'b0);
        chkb(avdEnable, 1'b1);
        @(posedge clk);
        cpuIntMask <= 1'b0;
        waitMode <= 1'b1;
        @(posedge clk);
        #1 chkb(avdIrq, 1'b1);
        chkb(waitWake, 1'b1);
        @(posedge clk);
        haltMode <= 1'b1;
        @(posedge clk);
        #1 chkb(avdIrq, 1'b0);
        @(posedge clk);
        haltMode <= 1'b0;
        avdIsrEntry <= 1'b1;
        @(posedge clk);
        avdIsrEntry <= 1'b0;
        #1 chkb(avdIrq, 1'b0);
        @(posedge clk);
        waitMode <= 1'b0;
        avdCompLow <= 1'b0;
        repeat (8) @(posedge clk);
        rd(4'h0, 1'b0);
        $display("test supply warning done");
        optUvdEnable <= 1'b0;
        pllLockIn <= 1'b0;
        avdCompLow <= 1'b1;
        repeat (8) @(posedge clk);
        chkb(avdEnable, 1'b0);
        rd(4'h0, 1'b0);
        for (int lv = 0; lv < 4; lv++) begin
            optUvdLevel <= 2'(lv);
            repeat (3) @(posedge clk);
            #1 chk16({14'h0, uvdLevel}, 16'(lv));
            @(posedge clk);
        end
        clkEn <= 1'b0;
        optUvdLevel <= 2'h1;
        repeat (4) @(posedge clk);
        #1 chk16({14'h0, uvdLevel}, 16'h0003);
        $display("test options done");
        finishTest();
    end
endmodule
